// ### iopcd_pkg.sv
// constants for the pin configuration decoder, plus the per-pin mode decoder
// assumes one synchronous clock domain and a simple strobe register port
//
// Overview of operation
// - input-only pin never drives; others bidirectional
// - input-only mode: plain, schmitt, low-voltage, reserved
// - input-only pin resistor: pull-down, four values
// - bidirectional mode field selects eight pad modes
// - bidirectional resistor value: floating, 10k, 100k, 1M
// - direction bit: 0 pull-down, 1 pull-up
// - drive bit: 0 single, 1 double strength
// - outputs and analog only on allowed pins
// - programming mode hands pins to programmer
`timescale 1ns/100ps

package iopcd_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_PIN2   = 8'h00;
  localparam logic [7:0] OFS_PIN3   = 8'h01;
  localparam logic [7:0] OFS_PIN4   = 8'h02;
  localparam logic [7:0] OFS_CTRL   = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // ==========================================================
  // field layout of the input-only pin word
  localparam int P2_MODE_LSB = 0;
  localparam int P2_VAL_LSB  = 2;
  localparam int P2_W        = 4;
  // field layout of a bidirectional pin word
  localparam int BP_MODE_LSB = 0;
  localparam int BP_VAL_LSB  = 3;
  localparam int BP_DIR_BIT  = 5;
  localparam int BP_DRV_BIT  = 6;
  localparam int BP_W        = 7;
  // control and status bits
  localparam int CTRL_LOCK_BIT = 0;
  localparam int ST_LOCK_BIT   = 0;
  localparam int ST_PROG_BIT   = 1;
  localparam int ST_PAD_LSB    = 2;
  // ==========================================================
  // reset values: plain input, floating resistor
  localparam logic [3:0] P2_RESET = 4'h0;
  localparam logic [6:0] BP_RESET = 7'h00;
  // ==========================================================
  // mode codes
  localparam logic [1:0] P2_PLAIN   = 2'h0;
  localparam logic [1:0] P2_SCHMITT = 2'h1;
  localparam logic [1:0] P2_LOWV    = 2'h2;
  localparam logic [2:0] BM_PLAIN   = 3'h0;
  localparam logic [2:0] BM_SCHMITT = 3'h1;
  localparam logic [2:0] BM_LOWV    = 3'h2;
  localparam logic [2:0] BM_ANALOG  = 3'h3;
  localparam logic [2:0] BM_PP      = 3'h4;
  localparam logic [2:0] BM_OD_N    = 3'h5;
  localparam logic [2:0] BM_OD_P    = 3'h6;
  localparam logic [2:0] BM_AN_ODN  = 3'h7;
  // configuration lock state
  typedef enum logic {CFG_OPEN, CFG_LOCKED} iopcd_lock_t;
endpackage

// ============================================================
// combinational decode of one bidirectional pin mode
module iopcd_pin_decode (
  // configuration and fabric data
  input  wire logic [2:0] mode,
  input  wire logic       fab_d,
  // pad attributes
  output logic            drv_oe,
  output logic            drv_o,
  output logic            dig_in_en,
  output logic            schmitt,
  output logic            lowv,
  output logic            analog
);
  // one case covers all eight codes so no mode can float
  always_comb begin
    drv_oe    = 1'b0;
    drv_o     = 1'b0;
    dig_in_en = 1'b1;
    schmitt   = 1'b0;
    lowv      = 1'b0;
    analog    = 1'b0;
    case (mode)
      iopcd_pkg::BM_PLAIN: begin
      end
      iopcd_pkg::BM_SCHMITT: schmitt = 1'b1;
      iopcd_pkg::BM_LOWV: lowv = 1'b1;
      iopcd_pkg::BM_ANALOG: begin
        analog    = 1'b1;
        dig_in_en = 1'b0;
      end
      iopcd_pkg::BM_PP: begin
        drv_oe = 1'b1;
        drv_o  = fab_d;
      end
      iopcd_pkg::BM_OD_N: drv_oe = ~fab_d; // sinks low only
      iopcd_pkg::BM_OD_P: begin
        drv_oe = fab_d; // sources high only
        drv_o  = 1'b1;
      end
      iopcd_pkg::BM_AN_ODN: begin
        analog = 1'b1;
        drv_oe = ~fab_d;
      end
      default: begin
      end
    endcase
  end
endmodule

// ### iopcd_top.sv
// top of the pin configuration decoder: config registers, lock, pad control
// assumes pads, resistors and drivers sit outside and obey these controls
`timescale 1ns/100ps

module iopcd_top #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // programming mode select
  input  wire logic              prog_mode,
  // input-only pin
  input  wire logic              p2_pad_i,
  output logic                   p2_fab_in,
  output logic                   p2_schmitt,
  output logic                   p2_lowv,
  output logic      [1:0]        p2_pull_val,
  output logic                   p2_pull_up,
  // bidirectional pins, index 0 and 1 are the two comparator pins
  input  wire logic [1:0]        bp_pad_i,
  output logic      [1:0]        bp_pad_o,
  output logic      [1:0]        bp_pad_oe,
  input  wire logic [1:0]        bp_fab_out,
  output logic      [1:0]        bp_fab_in,
  output logic      [1:0]        bp_schmitt,
  output logic      [1:0]        bp_lowv,
  output logic      [1:0]        bp_analog,
  output logic      [1:0]        bp_pull_val0,
  output logic      [1:0]        bp_pull_val1,
  output logic      [1:0]        bp_pull_up,
  output logic      [1:0]        bp_drive_2x,
  // programming functions
  output logic                   prog_vpp_sense,
  output logic                   prog_id,
  input  wire logic              pm_ctl_pad_i,
  input  wire logic              pm_sdio_pad_i,
  output logic                   pm_sdio_pad_o,
  output logic                   pm_sdio_pad_oe,
  input  wire logic              pm_rw_pad_i,
  input  wire logic              pm_scl_pad_i,
  output logic                   prog_ctl,
  output logic                   prog_sdio_in,
  input  wire logic              prog_sdio_out,
  input  wire logic              prog_sdio_drive,
  output logic                   program_read_write_select,
  output logic                   prog_scl
);

  // all checks run on the one clock and sleep through reset
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // configuration registers and lock
  logic [3:0] p2_cfg_r, p2_cfg_nxt;
  logic [6:0] bp_cfg_r [2];
  logic [6:0] bp_cfg_nxt [2];
  iopcd_pkg::iopcd_lock_t lock_r, lock_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic wr_ok;
  logic is_locked;

  // one lock decode shared by the control and status read-back
  assign is_locked = (lock_r == iopcd_pkg::CFG_LOCKED);

  // reserved input-only code reads back as stored but decodes as plain
  function automatic logic [1:0] p2_mode_dec(input logic [1:0] m);
    p2_mode_dec = (m == iopcd_pkg::P2_LOWV || m == iopcd_pkg::P2_SCHMITT)
                  ? m : iopcd_pkg::P2_PLAIN;
  endfunction

  // writes land only while open; lock holds until power-on reset
  always_comb begin
    wr_ok      = reg_wr && (lock_r == iopcd_pkg::CFG_OPEN);
    p2_cfg_nxt = p2_cfg_r;
    lock_nxt   = lock_r;
    for (int i = 0; i < 2; i++) bp_cfg_nxt[i] = bp_cfg_r[i];
    if (wr_ok && reg_addr == iopcd_pkg::OFS_PIN2)
      p2_cfg_nxt = reg_wdata[3:0];
    if (wr_ok && reg_addr == iopcd_pkg::OFS_PIN3)
      bp_cfg_nxt[0] = reg_wdata[6:0];
    if (wr_ok && reg_addr == iopcd_pkg::OFS_PIN4)
      bp_cfg_nxt[1] = reg_wdata[6:0];
    if (wr_ok && reg_addr == iopcd_pkg::OFS_CTRL &&
        reg_wdata[iopcd_pkg::CTRL_LOCK_BIT])
      lock_nxt = iopcd_pkg::CFG_LOCKED;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        iopcd_pkg::OFS_PIN2: rdata_nxt[3:0] = p2_cfg_r;
        iopcd_pkg::OFS_PIN3: rdata_nxt[6:0] = bp_cfg_r[0];
        iopcd_pkg::OFS_PIN4: rdata_nxt[6:0] = bp_cfg_r[1];
        iopcd_pkg::OFS_CTRL:
          rdata_nxt[iopcd_pkg::CTRL_LOCK_BIT] = is_locked;
        iopcd_pkg::OFS_STATUS: begin
          rdata_nxt[iopcd_pkg::ST_LOCK_BIT] = is_locked;
          rdata_nxt[iopcd_pkg::ST_PROG_BIT] = prog_mode;
          rdata_nxt[iopcd_pkg::ST_PAD_LSB +: 3] = {bp_fab_in, p2_fab_in};
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      p2_cfg_r    <= iopcd_pkg::P2_RESET;
      bp_cfg_r[0] <= iopcd_pkg::BP_RESET;
      bp_cfg_r[1] <= iopcd_pkg::BP_RESET;
      lock_r      <= iopcd_pkg::CFG_OPEN;
      reg_rdata   <= '0;
    end else begin
      p2_cfg_r    <= p2_cfg_nxt;
      bp_cfg_r[0] <= bp_cfg_nxt[0];
      bp_cfg_r[1] <= bp_cfg_nxt[1];
      lock_r      <= lock_nxt;
      reg_rdata   <= rdata_nxt;
    end
  end

  // ==========================================================
  // bidirectional pin decode
  logic [1:0] d_oe, d_o, d_in_en, d_sch, d_lowv, d_an;
  logic [1:0] oe_nxt, o_nxt, fin_nxt, sch_nxt, lowv_nxt, an_nxt;
  logic [1:0] pu_nxt, d2x_nxt, pv0_nxt, pv1_nxt;

  for (genvar g = 0; g < 2; g++) begin : g_dec
    iopcd_pin_decode u_dec (
      .mode      (bp_cfg_r[g][iopcd_pkg::BP_MODE_LSB +: 3]),
      .fab_d     (bp_fab_out[g]),
      .drv_oe    (d_oe[g]),
      .drv_o     (d_o[g]),
      .dig_in_en (d_in_en[g]),
      .schmitt   (d_sch[g]),
      .lowv      (d_lowv[g]),
      .analog    (d_an[g])
    );
  end

  // programming mode takes the drivers away from the fabric
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      oe_nxt[i]   = d_oe[i] && !prog_mode;
      o_nxt[i]    = d_o[i];
      fin_nxt[i]  = d_in_en[i] && bp_pad_i[i];
      sch_nxt[i]  = d_sch[i];
      lowv_nxt[i] = d_lowv[i];
      an_nxt[i]   = d_an[i];
      pu_nxt[i]   = bp_cfg_r[i][iopcd_pkg::BP_DIR_BIT];
      d2x_nxt[i]  = bp_cfg_r[i][iopcd_pkg::BP_DRV_BIT];
    end
    pv0_nxt = bp_cfg_r[0][iopcd_pkg::BP_VAL_LSB +: 2];
    pv1_nxt = bp_cfg_r[1][iopcd_pkg::BP_VAL_LSB +: 2];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bp_pad_oe    <= '0;
      bp_pad_o     <= '0;
      bp_fab_in    <= '0;
      bp_schmitt   <= '0;
      bp_lowv      <= '0;
      bp_analog    <= '0;
      bp_pull_up   <= '0;
      bp_drive_2x  <= '0;
      bp_pull_val0 <= '0;
      bp_pull_val1 <= '0;
    end else begin
      bp_pad_oe    <= oe_nxt;
      bp_pad_o     <= o_nxt;
      bp_fab_in    <= fin_nxt;
      bp_schmitt   <= sch_nxt;
      bp_lowv      <= lowv_nxt;
      bp_analog    <= an_nxt;
      bp_pull_up   <= pu_nxt;
      bp_drive_2x  <= d2x_nxt;
      bp_pull_val0 <= pv0_nxt;
      bp_pull_val1 <= pv1_nxt;
    end
  end

  // ==========================================================
  // input-only pin and programming functions
  logic [1:0] p2m;
  logic       sdio_oe_nxt;
  assign p2m = p2_mode_dec(p2_cfg_r[iopcd_pkg::P2_MODE_LSB +: 2]);
  assign sdio_oe_nxt = prog_mode && prog_sdio_drive;

  // this pin has no driver at all, only an input path
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      p2_fab_in      <= 1'b0;
      p2_schmitt     <= 1'b0;
      p2_lowv        <= 1'b0;
      p2_pull_val    <= 2'h0;
      p2_pull_up     <= 1'b0;
      prog_vpp_sense <= 1'b0;
      prog_id        <= 1'b0;
      prog_ctl       <= 1'b0;
      prog_sdio_in   <= 1'b0;
      pm_sdio_pad_o  <= 1'b0;
      pm_sdio_pad_oe <= 1'b0;
      program_read_write_select <= 1'b0;
      prog_scl       <= 1'b0;
    end else begin
      p2_fab_in      <= p2_pad_i && !prog_mode;
      p2_schmitt     <= (p2m == iopcd_pkg::P2_SCHMITT);
      p2_lowv        <= (p2m == iopcd_pkg::P2_LOWV);
      p2_pull_val    <= p2_cfg_r[iopcd_pkg::P2_VAL_LSB +: 2];
      p2_pull_up     <= 1'b0;
      prog_vpp_sense <= prog_mode && p2_pad_i;
      prog_id        <= prog_mode && bp_pad_i[0];
      prog_ctl       <= prog_mode && pm_ctl_pad_i;
      prog_sdio_in   <= prog_mode && pm_sdio_pad_i;
      pm_sdio_pad_o  <= prog_sdio_out;
      pm_sdio_pad_oe <= sdio_oe_nxt;
      program_read_write_select <= prog_mode && pm_rw_pad_i;
      prog_scl       <= prog_mode && pm_scl_pad_i;
    end
  end

  // ==========================================================
  // checks
  sequence s_lock_wr;
    reg_wr && reg_addr == iopcd_pkg::OFS_CTRL &&
    reg_wdata[iopcd_pkg::CTRL_LOCK_BIT];
  endsequence
  sequence s_held_locked;
    (lock_r == iopcd_pkg::CFG_LOCKED) [*3];
  endsequence

  AST_LOCK_STICKS: assert property (s_lock_wr |=> s_held_locked)
    else $error("lock did not stick");
  AST_FROZEN: assert property (
    lock_r == iopcd_pkg::CFG_LOCKED
    |=> $stable(bp_cfg_r[0]) && $stable(bp_cfg_r[1]) && $stable(p2_cfg_r))
    else $error("config changed after lock");
  AST_P2_RESERVED: assert property (
    p2_cfg_r[1:0] == 2'h3 |=> !p2_schmitt && !p2_lowv)
    else $error("reserved code not plain input");
  AST_P2_SCHMITT: assert property (
    p2_cfg_r[1:0] == iopcd_pkg::P2_SCHMITT |=> p2_schmitt && !p2_lowv)
    else $error("schmitt mode not decoded");
  AST_P2_PULL: assert property (
    ##1 !p2_pull_up && p2_pull_val == $past(p2_cfg_r[3:2]))
    else $error("input-only pull wrong");
  AST_PP_DRIVE: assert property (
    bp_cfg_r[0][2:0] == iopcd_pkg::BM_PP && !prog_mode
    |=> bp_pad_oe[0] && bp_pad_o[0] == $past(bp_fab_out[0]))
    else $error("push-pull not driving");
  AST_ODN: assert property (
    bp_cfg_r[1][2:0] == iopcd_pkg::BM_OD_N && !prog_mode
    |=> bp_pad_oe[1] == !$past(bp_fab_out[1]) && !bp_pad_o[1])
    else $error("open drain nmos wrong");
  AST_PULL_DIR: assert property (
    ##1 bp_pull_up[0] == $past(bp_cfg_r[0][5])
    && bp_pull_val0 == $past(bp_cfg_r[0][4:3]))
    else $error("pull select wrong");
  AST_DRIVE_2X: assert property (
    ##1 bp_drive_2x[1] == $past(bp_cfg_r[1][6]))
    else $error("drive strength wrong");
  AST_ANALOG: assert property (
    bp_analog[0] |-> $past(bp_cfg_r[0][1:0]) == 2'h3)
    else $error("analog in wrong mode");
  AST_PROG_RELEASE: assert property (
    prog_mode |=> bp_pad_oe == 2'h0 && prog_id == $past(bp_pad_i[0]))
    else $error("programming mode pins wrong");
endmodule

// ### iopcd_board.sv
// board model: pad wires with pulls, external drivers and a programmer
// assumes the decoder drives a pad only while its output enable is high
`timescale 1ns/100ps

module iopcd_board (
  // decoder pad drive
  input  wire logic [1:0] pad_o,
  input  wire logic [1:0] pad_oe,
  input  wire logic [1:0] pull_up,
  input  wire logic [1:0] pull_on,
  input  wire logic       sdio_o,
  input  wire logic       sdio_oe,
  // board side levels
  input  wire logic [1:0] ext_en,
  input  wire logic [1:0] ext_lvl,
  input  wire logic       pgm_lvl,
  // resolved pad levels
  output logic      [1:0] pad_i,
  output logic            sdio_i
);
  logic tog;

  // ========================================================
  // a floating pad wanders twice per clock period, so every sampling edge sees the same level
  initial begin
    tog = 1'b0;
    #10; // keep the wander clear of the sampling edge
    forever #20 tog = ~tog;
  end

  // wire resolution, device first, then board, then resistor
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (pad_oe[k]) begin
        pad_i[k] = pad_o[k];
      end else if (ext_en[k]) begin
        pad_i[k] = ext_lvl[k];
      end else if (pull_on[k]) begin
        pad_i[k] = pull_up[k];
      end else begin
        pad_i[k] = tog;
      end
    end
  end

  // programmer owns the data line unless the device drives it
  assign sdio_i = sdio_oe ? sdio_o : pgm_lvl;
endmodule

// ### test_iopcd_top.sv
// self-checking bench for the pin configuration decoder
// assumes iopcd_pkg and the board model are compiled first
`timescale 1ns/100ps

module test_iopcd_top;
  // ========================================================
  // signals
  logic        sys_clk, reset, reg_wr, reg_rd, prog_mode, p2_pad_i;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic        p2_fab_in, p2_schmitt, p2_lowv, p2_pull_up;
  logic [1:0]  p2_pull_val, bp_pad_i, bp_pad_o, bp_pad_oe, bp_fab_out;
  logic [1:0]  bp_fab_in, bp_schmitt, bp_lowv, bp_analog, bp_pull_up;
  logic [1:0]  bp_pull_val0, bp_pull_val1, bp_drive_2x, ext_en, ext_lvl;
  logic        prog_vpp_sense, prog_id, pm_ctl_pad_i, pm_sdio_pad_i;
  logic        pm_sdio_pad_o, pm_sdio_pad_oe, pm_rw_pad_i, pm_scl_pad_i;
  logic        prog_ctl, prog_sdio_in, prog_sdio_out, prog_sdio_drive;
  logic        program_read_write_select, prog_scl, pgm_lvl;
  int          miscompares, total_checks;

  iopcd_top iopcd_top_i (.*);
  iopcd_board iopcd_board_i (.pad_o(bp_pad_o), .pad_oe(bp_pad_oe),
    .pull_up(bp_pull_up), .pull_on({|bp_pull_val1, |bp_pull_val0}),
    .sdio_o(pm_sdio_pad_o), .sdio_oe(pm_sdio_pad_oe), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pgm_lvl(pgm_lvl), .pad_i(bp_pad_i),
    .sdio_i(pm_sdio_pad_i));

  // ========================================================
  // clock, time-zero values and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 40'h0};
    {prog_mode, p2_pad_i, pm_ctl_pad_i, pm_rw_pad_i, pm_scl_pad_i} = 5'h0;
    {bp_fab_out, ext_en, ext_lvl} = 6'h0c;
    {prog_sdio_out, prog_sdio_drive, pgm_lvl} = 3'h0;
    #400_000;
    miscompares++;
    print_verdict();
  end

  // ========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ========================================================
  // scenarios
  task automatic t_input_only;
    for (int c = 0; c < 4; c++) begin
      wr(iopcd_pkg::OFS_PIN2, 32'((3 - c) * 4 + c));
      p2_pad_i <= c[0];
      settle();
      chk("p2_schmitt", 32'(p2_schmitt), 32'(c == 1));
      chk("p2_lowv", 32'(p2_lowv), 32'(c == 2));
      chk("p2_fab_in", 32'(p2_fab_in), 32'(c[0]));
      chk("p2_pull_val", 32'(p2_pull_val), 32'(3 - c));
      chk("p2_pull_up", 32'(p2_pull_up), 32'h0000_0000);
      rd(iopcd_pkg::OFS_PIN2, rv);
      chk("p2_word", rv, 32'((3 - c) * 4 + c));
    end
  endtask
  task automatic t_bidir_modes;
    logic [2:0] m;
    logic d, oe, od;
    for (int i = 0; i < 32; i++) begin
      m  = 3'(i >> 1);
      d  = i[0];
      od = (m == iopcd_pkg::BM_OD_N) || (m == iopcd_pkg::BM_AN_ODN);
      oe = (m == iopcd_pkg::BM_PP) || (od && !d)
           || (m == iopcd_pkg::BM_OD_P && d);
      wr(iopcd_pkg::OFS_PIN3 + 8'(i[4]), {29'h0, m});
      bp_fab_out[i[4]] <= d;
      ext_lvl[i[4]]    <= ~d;
      settle();
      chk("pad_oe", 32'(bp_pad_oe[i[4]]), 32'(oe));
      if (oe) begin
        chk("pad_o", 32'(bp_pad_o[i[4]]), 32'(m == 4 ? d : m == 6));
      end
      chk("schmitt", 32'(bp_schmitt[i[4]]), 32'(m == 1));
      chk("lowv", 32'(bp_lowv[i[4]]), 32'(m == 2));
      chk("analog", 32'(bp_analog[i[4]]), 32'(m == 3 || m == 7));
      if (m == 3 || (!oe && m != 4 && m != 5 && m != 6)) begin
        chk("fab_in", 32'(bp_fab_in[i[4]]), 32'(m != 3 && !d));
      end
    end
  endtask
  task automatic t_pulls;
    ext_en <= 2'b00;
    for (int v = 1; v < 4; v++) begin
      wr(iopcd_pkg::OFS_PIN3, 32'(v * 8 + v * 32));
      wr(iopcd_pkg::OFS_PIN4, 32'((3 - v) * 8 + (3 - v) * 32));
      settle();
      chk("pull_val0", 32'(bp_pull_val0), 32'(v));
      chk("pull_val1", 32'(bp_pull_val1), 32'(3 - v));
      chk("pull_up", 32'(bp_pull_up), 32'((3 - v) % 2 * 2 + v % 2));
      chk("drive_2x", 32'(bp_drive_2x), 32'((3 - v) / 2 * 2 + v / 2));
      chk("pulled_in", 32'(bp_fab_in[0]), 32'(v % 2));
    end
    ext_en <= 2'b11;
  endtask
  task automatic t_lock_and_prog;
    wr(iopcd_pkg::OFS_PIN3, {29'h0, iopcd_pkg::BM_PP});
    wr(iopcd_pkg::OFS_CTRL, 32'h0000_0001);
    wr(iopcd_pkg::OFS_PIN3, 32'h0000_0000);
    wr(iopcd_pkg::OFS_PIN2, 32'h0000_0000);
    rd(iopcd_pkg::OFS_PIN3, rv);
    chk("locked_word", rv, 32'h0000_0004);
    rd(iopcd_pkg::OFS_PIN2, rv);
    chk("locked_p2", rv, 32'h0000_0003);
    rd(iopcd_pkg::OFS_CTRL, rv);
    chk("ctrl_lock", rv, 32'h0000_0001);
    rd(8'h3c, rv);
    chk("unmapped", rv, 32'h0000_0000);
    @(posedge sys_clk);
    {prog_mode, p2_pad_i, pm_ctl_pad_i, pm_scl_pad_i, pgm_lvl} <= 5'h1f;
    {pm_rw_pad_i, ext_lvl} <= 3'h1;
    settle();
    chk("prog_oe", 32'(bp_pad_oe), 32'h0000_0000);
    chk("prog_p2_in", 32'(p2_fab_in), 32'h0000_0000);
    chk("prog_pins", 32'({prog_vpp_sense, prog_id, prog_ctl, prog_sdio_in,
        program_read_write_select, prog_scl}), 32'h0000_003d);
    rd(iopcd_pkg::OFS_STATUS, rv);
    chk("status", rv, 32'h0000_000b);
    @(posedge sys_clk);
    {prog_sdio_drive, prog_sdio_out, pm_rw_pad_i} <= 3'h5;
    settle();
    chk("sdio_drv", 32'({pm_sdio_pad_oe, pm_sdio_pad_o}), 32'h2);
    chk("rw_sel", 32'(program_read_write_select), 32'h1);
    @(posedge sys_clk);
    prog_mode <= 1'b0;
    settle();
    chk("prog_off", 32'({prog_vpp_sense, prog_ctl, prog_scl}), 32'h0);
    do_reset();
    rd(iopcd_pkg::OFS_PIN3, rv);
    chk("reset_word", rv, 32'h0000_0000);
    rd(iopcd_pkg::OFS_STATUS, rv);
    chk("reset_lock", rv & 32'h0000_0001, 32'h0000_0000);
  endtask

  // ========================================================
  // main sequence
  initial begin
    do_reset();
    rd(iopcd_pkg::OFS_PIN4, rv);
    chk("pin4_reset", rv, 32'h0000_0000);
    t_input_only();
    t_bidir_modes();
    t_pulls();
    t_lock_and_prog();
    print_verdict();
  end
endmodule
